// *** core/lpm_pkg.sv ***
// package for the low-power mode controller: offsets, field positions, timing, types
// assumes a single 100 MHz core clock and a byte-wide register port
`default_nettype none
package lpm_pkg;
   localparam int ADDR_W = 8; // register port address width
   localparam int DATA_W = 8; // register port data width
   // register offsets
   localparam logic [7:0] CLK_CTRL0_OFS = 8'h00; // system_clock_control_0
   localparam logic [7:0] CLK_CTRL1_OFS = 8'h01; // system_clock_control_1
   localparam logic [7:0] PROTECT_OFS = 8'h02; // protect register
   localparam logic [7:0] CONV_CTRL1_OFS = 8'h03; // converter_control_1
   localparam logic [7:0] STATUS_OFS = 8'h04; // read-only status
   // field positions
   localparam int WAIT_PCLK_STOP_POS = 2; // wait_periph_clock_stop_bit in control 0
   localparam int DRIVE_LOW_POS = 5; // oscillator drive low in control 0
   localparam int STOP_ALL_POS = 0; // stop_all_clocks_bit in control 1
   localparam int PWE_POS = 2; // protect_write_enable_bit
   localparam int VREF_POS = 5; // vref_connect_bit in converter control 1
   localparam int ST_STOP_POS = 0; // status: in stop mode
   localparam int ST_WAIT_POS = 1; // status: in wait mode
   localparam int ST_REF_POS = 2; // status: reference settled
   localparam int ST_OSC_POS = 3; // status: oscillator restarting
   localparam int ST_NMI_POS = 4; // status: nmi pin level
   // timing
   localparam int CLK_PERIOD_NS = 10; // core_clk period
   localparam int REF_SETTLE_NS = 1000; // least reference settle time
   localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8; // width of the shared counters
   // power states
   typedef enum logic [2:0] {PM_RUN, PM_STOP_DRAIN, PM_STOP, PM_OSC_RESTART, PM_WAIT_DRAIN, PM_WAIT} pm_state_t;
   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   // clock gating outputs
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic subclock_div32_peripheral_clock_clk_en;
      logic osc_en;
      logic port_hold;
   } clk_ctrl_t;
endpackage
`default_nettype wire

// *** core/low_power_mode_control.sv ***
// low-power mode controller: stop and wait entry and exit, clock gating,
// one-shot write protect, converter reference settling
// assumes the cpu raises a one-cycle pulse when it executes the wait instruction
// and one for every write it makes elsewhere; wake and nmi arrive from pins
//
// Notes on behaviour
// - stop bit set halts every clock
// - queued instructions still run before stop halts
// - queued instructions still run before wait halts
// - ports hold state in wait and stop
// - wait stop bit gates peripheral clocks; div32 runs
// - conversion starts only after 1 us settle
// - first write after protect enable clears it
// - nmi low forces stop bit to zero
//
// Chosen here: the placing of the registers and the plain strobed port.
`default_nettype none
module low_power_mode_control #(
   parameter int QUEUE_DRAIN = 4, // cycles the prefetch queue keeps running after entry
   parameter int OSC_SETTLE = 64 // cycles the oscillator needs after restart
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // register port
   input wire lpm_pkg::bus_req_t bus_req,
   output logic [lpm_pkg::DATA_W-1:0] rdata,
   // cpu events, same clock
   input wire logic cpu_wait_exec,
   input wire logic mem_write,
   input wire logic conv_req,
   // pins, asynchronous
   input wire logic wake_pin,
   input wire logic nmi_n_pin,
   // controls
   output lpm_pkg::clk_ctrl_t clk_ctrl,
   output logic vref_connect,
   output logic conv_start,
   output logic osc_drive_low
);
   import lpm_pkg::*;

   if (QUEUE_DRAIN < 1 || QUEUE_DRAIN > 255) begin : g_bad_drain
      $error("QUEUE_DRAIN out of range");
   end
   if (OSC_SETTLE < 1 || OSC_SETTLE > 255 || REF_SETTLE_CYC > 255) begin : g_bad_osc
      $error("settle counts out of range");
   end

   localparam logic [CNT_W-1:0] DRAIN_LOAD = CNT_W'(QUEUE_DRAIN - 1);
   localparam logic [CNT_W-1:0] OSC_LOAD = CNT_W'(OSC_SETTLE - 1);
   localparam logic [CNT_W-1:0] REF_DONE = CNT_W'(REF_SETTLE_CYC);

   // all state of the block
   typedef struct packed {
      pm_state_t state;
      logic stop_bit; // stop_all_clocks_bit
      logic wait_pclk_stop; // wait_periph_clock_stop_bit
      logic drive_low; // oscillator drive capacity low
      logic pwe; // protect_write_enable_bit
      logic vref; // vref_connect_bit
      logic [CNT_W-1:0] cnt; // drain and oscillator counter
      logic [CNT_W-1:0] ref_cnt; // reference settle counter
      logic wake_s1, wake_s2; // wake synchroniser
      logic nmi_s1, nmi_s2; // nmi synchroniser
      logic conv_start;
      logic [DATA_W-1:0] rdata;
      clk_ctrl_t clk;
   } lpm_state_t;

   // nmi synchroniser resets high so reset does not look like an nmi
   localparam lpm_state_t RST_ST = '{state: PM_RUN, nmi_s1: 1'b1, nmi_s2: 1'b1,
      clk: '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, subclock_div32_peripheral_clock_clk_en: 1'b1, osc_en: 1'b1, port_hold: 1'b0},
      default: '0};

   lpm_state_t st_ff, nxt_st;

   // write decode, used for every writable register
   function automatic logic wr_hit(input bus_req_t r, input logic [ADDR_W-1:0] ofs);
      wr_hit = r.wr && (r.addr == ofs);
   endfunction

   logic any_write; // a cpu write anywhere
   assign any_write = bus_req.wr | mem_write;

   // next-state logic
   always_comb begin
      nxt_st = st_ff;
      nxt_st.wake_s1 = wake_pin;
      nxt_st.wake_s2 = st_ff.wake_s1;
      nxt_st.nmi_s1 = nmi_n_pin;
      nxt_st.nmi_s2 = st_ff.nmi_s1;
      nxt_st.conv_start = 1'b0;
      nxt_st.rdata = '0;
      // read mux, unmapped offsets read zero
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            CLK_CTRL0_OFS: begin
               nxt_st.rdata[WAIT_PCLK_STOP_POS] = st_ff.wait_pclk_stop;
               nxt_st.rdata[DRIVE_LOW_POS] = st_ff.drive_low;
            end
            CLK_CTRL1_OFS: nxt_st.rdata[STOP_ALL_POS] = st_ff.stop_bit;
            PROTECT_OFS: nxt_st.rdata[PWE_POS] = st_ff.pwe;
            CONV_CTRL1_OFS: nxt_st.rdata[VREF_POS] = st_ff.vref;
            STATUS_OFS: begin
               nxt_st.rdata[ST_STOP_POS] = (st_ff.state == PM_STOP);
               nxt_st.rdata[ST_WAIT_POS] = (st_ff.state == PM_WAIT);
               nxt_st.rdata[ST_REF_POS] = (st_ff.ref_cnt == REF_DONE);
               nxt_st.rdata[ST_OSC_POS] = (st_ff.state == PM_OSC_RESTART);
               nxt_st.rdata[ST_NMI_POS] = st_ff.nmi_s2;
            end
            default: nxt_st.rdata = '0;
         endcase
      end
      // one-shot protect: any write after enabling clears it, a fresh set wins
      if (st_ff.pwe && any_write) begin
         nxt_st.pwe = 1'b0;
      end
      if (wr_hit(bus_req, PROTECT_OFS)) begin
         nxt_st.pwe = bus_req.wdata[PWE_POS];
      end
      if (wr_hit(bus_req, CLK_CTRL0_OFS)) begin
         nxt_st.wait_pclk_stop = bus_req.wdata[WAIT_PCLK_STOP_POS];
         nxt_st.drive_low = bus_req.wdata[DRIVE_LOW_POS];
      end
      if (wr_hit(bus_req, CONV_CTRL1_OFS)) begin
         nxt_st.vref = bus_req.wdata[VREF_POS];
      end
      // reference settle: count from connect, restart on disconnect
      if (!nxt_st.vref) begin
         nxt_st.ref_cnt = '0;
      end else if (st_ff.ref_cnt != REF_DONE) begin
         nxt_st.ref_cnt = st_ff.ref_cnt + 1'b1;
      end
      // requests before the reference settles are dropped
      if (conv_req && st_ff.vref && st_ff.ref_cnt == REF_DONE) begin
         nxt_st.conv_start = 1'b1;
      end
      // power state machine
      unique case (st_ff.state)
         PM_RUN: begin
            if (wr_hit(bus_req, CLK_CTRL1_OFS) && bus_req.wdata[STOP_ALL_POS] && st_ff.nmi_s2) begin
               nxt_st.stop_bit = 1'b1;
               nxt_st.cnt = DRAIN_LOAD;
               nxt_st.state = PM_STOP_DRAIN;
            end else if (cpu_wait_exec) begin
               nxt_st.cnt = DRAIN_LOAD;
               nxt_st.state = PM_WAIT_DRAIN;
            end
         end
         PM_STOP_DRAIN: begin
            // the queue keeps executing for a few cycles before the halt
            if (st_ff.cnt == '0) begin
               nxt_st.state = PM_STOP;
            end else begin
               nxt_st.cnt = st_ff.cnt - 1'b1;
            end
         end
         PM_STOP: begin
            if (st_ff.wake_s2 || !st_ff.nmi_s2) begin
               nxt_st.stop_bit = 1'b0;
               nxt_st.cnt = OSC_LOAD;
               nxt_st.state = PM_OSC_RESTART;
            end
         end
         PM_OSC_RESTART: begin
            // cpu stays halted until the oscillator has had its settle time
            if (st_ff.cnt == '0) begin
               nxt_st.state = PM_RUN;
            end else begin
               nxt_st.cnt = st_ff.cnt - 1'b1;
            end
         end
         PM_WAIT_DRAIN: begin
            if (st_ff.cnt == '0) begin
               nxt_st.state = PM_WAIT;
            end else begin
               nxt_st.cnt = st_ff.cnt - 1'b1;
            end
         end
         PM_WAIT: begin
            if (st_ff.wake_s2 || !st_ff.nmi_s2) begin
               nxt_st.state = PM_RUN;
            end
         end
      endcase
      // nmi low pins the stop bit at zero and aborts a pending stop entry
      if (!st_ff.nmi_s2) begin
         nxt_st.stop_bit = 1'b0;
         if (st_ff.state == PM_STOP_DRAIN) begin
            nxt_st.state = PM_RUN;
         end
      end
      // clock controls follow the next state so outputs and state agree
      nxt_st.clk.cpu_clk_en = (nxt_st.state inside {PM_RUN, PM_STOP_DRAIN, PM_WAIT_DRAIN});
      nxt_st.clk.osc_en = (nxt_st.state != PM_STOP);
      nxt_st.clk.subclock_div32_peripheral_clock_clk_en = !(nxt_st.state inside {PM_STOP, PM_OSC_RESTART});
      nxt_st.clk.periph_clk_en = nxt_st.clk.subclock_div32_peripheral_clock_clk_en &&
         !(nxt_st.state == PM_WAIT && nxt_st.wait_pclk_stop);
      nxt_st.clk.port_hold = (nxt_st.state inside {PM_WAIT, PM_STOP, PM_OSC_RESTART});
   end

   // state register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= RST_ST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign rdata = st_ff.rdata;
   assign clk_ctrl = st_ff.clk;
   assign vref_connect = st_ff.vref;
   assign conv_start = st_ff.conv_start;
   assign osc_drive_low = st_ff.drive_low;

   // checks
   sequence s_stop_req;
      st_ff.state == PM_RUN && wr_hit(bus_req, CLK_CTRL1_OFS) && bus_req.wdata[STOP_ALL_POS] && st_ff.nmi_s2;
   endsequence
   sequence s_stop_wake;
      st_ff.state == PM_STOP && (st_ff.wake_s2 || !st_ff.nmi_s2);
   endsequence

   property p_stop_halts;
      @(posedge core_clk) disable iff (!rstn)
      st_ff.state == PM_STOP |-> !clk_ctrl.cpu_clk_en && !clk_ctrl.osc_en && !clk_ctrl.periph_clk_en;
   endproperty
   a_stop_halts: assert property (p_stop_halts) else $error("clock running in stop");

   property p_stop_drain;
      @(posedge core_clk) disable iff (!rstn)
      s_stop_req |=> st_ff.stop_bit && clk_ctrl.cpu_clk_en && st_ff.state == PM_STOP_DRAIN;
   endproperty
   a_stop_drain: assert property (p_stop_drain) else $error("stop entry did not drain queue");

   property p_wait_drain;
      @(posedge core_clk) disable iff (!rstn)
      st_ff.state == PM_RUN && cpu_wait_exec && !bus_req.wr |=> st_ff.state == PM_WAIT_DRAIN && clk_ctrl.cpu_clk_en;
   endproperty
   a_wait_drain: assert property (p_wait_drain) else $error("wait entry did not drain queue");

   property p_ports_hold;
      @(posedge core_clk) disable iff (!rstn)
      st_ff.state inside {PM_WAIT, PM_STOP} |-> clk_ctrl.port_hold;
   endproperty
   a_ports_hold: assert property (p_ports_hold) else $error("ports not held");

   property p_wait_pclk;
      @(posedge core_clk) disable iff (!rstn)
      st_ff.state == PM_WAIT |-> clk_ctrl.subclock_div32_peripheral_clock_clk_en && (clk_ctrl.periph_clk_en == !st_ff.wait_pclk_stop);
   endproperty
   a_wait_pclk: assert property (p_wait_pclk) else $error("wrong peripheral clock in wait");

   property p_ref_settle;
      @(posedge core_clk) disable iff (!rstn)
      $rose(vref_connect) |-> !conv_start [*8];
   endproperty
   a_ref_settle: assert property (p_ref_settle) else $error("conversion before settle");

   property p_conv_ready;
      @(posedge core_clk) disable iff (!rstn)
      conv_start |-> $past(st_ff.ref_cnt) == REF_DONE;
   endproperty
   a_conv_ready: assert property (p_conv_ready) else $error("conversion without settled reference");

   property p_pwe_clear;
      @(posedge core_clk) disable iff (!rstn)
      st_ff.pwe && any_write && !wr_hit(bus_req, PROTECT_OFS) |=> !st_ff.pwe;
   endproperty
   a_pwe_clear: assert property (p_pwe_clear) else $error("protect enable survived a write");

   property p_nmi_stop;
      @(posedge core_clk) disable iff (!rstn)
      !st_ff.nmi_s2 |=> !st_ff.stop_bit;
   endproperty
   a_nmi_stop: assert property (p_nmi_stop) else $error("stop bit set with nmi low");

   property p_stop_wake;
      @(posedge core_clk) disable iff (!rstn)
      s_stop_wake |=> st_ff.state == PM_OSC_RESTART && !st_ff.stop_bit && clk_ctrl.osc_en && !clk_ctrl.cpu_clk_en;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("bad stop wake sequence");
endmodule
`default_nettype wire

// *** testbench/cpu_side_model.sv ***
// partner model of the cpu program: turns bench commands into one-cycle event pulses
// assumes the bench raises each go bit for exactly one clock cycle
`default_nettype none
module cpu_side_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // commands from the bench: bit0 wait, bit1 memory write, bit2 conversion
   input wire logic [2:0] go,
   // events toward the controller
   output logic cpu_wait_exec,
   output logic mem_write,
   output logic conv_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] quiet_ff; // cycles of no-op padding still owed after a wait
   // events leave one cycle after the command, like the cpu retiring an instruction
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_wait_exec <= 1'b0;
         mem_write <= 1'b0;
         conv_req <= 1'b0;
         quiet_ff <= 3'h0;
      end else begin
         cpu_wait_exec <= go[0];
         // no ram write right after a wait: padding no-ops come first
         mem_write <= go[1] && (quiet_ff == 3'h0);
         // a conversion request passes straight through, with no padding after a wait
         conv_req <= go[2];
         if (go[0]) begin
            quiet_ff <= 3'h4;
         end else if (quiet_ff != 3'h0) begin
            quiet_ff <= quiet_ff - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/low_power_mode_control_tb.sv ***
// self-checking bench for the low-power mode controller
// assumes short drain and settle parameters; pins are driven directly by the bench
`default_nettype none
module low_power_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lpm_pkg::*;
   localparam int QD = 2; // shortened queue drain
   localparam int OS = 4; // shortened oscillator settle
   logic core_clk, rstn, cpu_wait_exec, mem_write, conv_req, wake_pin, nmi_n_pin;
   logic vref_connect, conv_start, osc_drive_low, seen;
   logic [2:0] go; // partner commands
   logic [7:0] rdata, v;
   bus_req_t bus_req;
   clk_ctrl_t clk_ctrl;
   int n_fail = 0, compares = 0, cyc = 0, n;
   low_power_mode_control #(.QUEUE_DRAIN(QD), .OSC_SETTLE(OS)) low_power_mode_control_inst (
      .core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .cpu_wait_exec(cpu_wait_exec),
      .mem_write(mem_write), .conv_req(conv_req), .wake_pin(wake_pin), .nmi_n_pin(nmi_n_pin),
      .clk_ctrl(clk_ctrl), .vref_connect(vref_connect), .conv_start(conv_start), .osc_drive_low(osc_drive_low));
   cpu_side_model cpu_side_model_inst (.core_clk(core_clk), .rstn(rstn), .go(go),
      .cpu_wait_exec(cpu_wait_exec), .mem_write(mem_write), .conv_req(conv_req));
   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // hang guard: far above the few hundred cycles the tests need
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask
   // one-cycle read strobe, data sampled in the following cycle only
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic pulse(input logic [2:0] m);
      @(posedge core_clk);
      go <= m;
      @(posedge core_clk);
      go <= 3'h0;
   endtask
   // bounded wait for one clock-control bit to reach a level; n returns cycles spent
   task automatic wait_bit(input int idx, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (clk_ctrl[idx] !== lvl && cnt < lim) begin
         @(posedge core_clk);
         #1;
         cnt++;
      end
   endtask
   task automatic watch_conv(output logic hit);
      hit = 1'b0;
      repeat (4) begin
         @(posedge core_clk);
         #1;
         if (conv_start === 1'b1) hit = 1'b1;
      end
   endtask
   initial begin
      rstn = 1'b0;
      bus_req = '0;
      go = 3'h0;
      wake_pin = 1'b0;
      nmi_n_pin = 1'b1;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk({3'h0, clk_ctrl}, 8'h1E);
      rd(STATUS_OFS, v);
      chk(v, 8'h10);
      rd(8'h7F, v);
      chk(v, 8'h00);
      wr(CLK_CTRL0_OFS, 8'h20);
      chk({7'h0, osc_drive_low}, 8'h01);
      // protect bit cleared by the next write of either kind
      wr(PROTECT_OFS, 8'h04);
      rd(PROTECT_OFS, v);
      chk(v, 8'h04);
      pulse(3'b010);
      repeat (2) @(posedge core_clk);
      rd(PROTECT_OFS, v);
      chk(v, 8'h00);
      wr(PROTECT_OFS, 8'h04);
      wr(CLK_CTRL0_OFS, 8'h00);
      rd(PROTECT_OFS, v);
      chk(v, 8'h00);
      // wait mode with and without peripheral clock stop
      for (int p = 0; p < 2; p++) begin
         wr(CLK_CTRL0_OFS, (p == 1) ? 8'h04 : 8'h00);
         pulse(3'b001);
         @(posedge core_clk);
         #1;
         chk({7'h0, clk_ctrl.cpu_clk_en}, 8'h01);
         wait_bit(4, 1'b0, QD + 6, n);
         chk({4'h0, clk_ctrl.cpu_clk_en, clk_ctrl.periph_clk_en, clk_ctrl.subclock_div32_peripheral_clock_clk_en, clk_ctrl.port_hold},
            {4'h0, 1'b0, p == 0, 2'b11});
         // status shows wait while the cpu is halted
         rd(STATUS_OFS, v);
         chk(v, 8'h12);
         wake_pin <= 1'b1;
         wait_bit(4, 1'b1, 8, n);
         wake_pin <= 1'b0;
         chk({3'h0, clk_ctrl}, 8'h1E);
      end
      wr(CLK_CTRL0_OFS, 8'h00);
      // stop entry, drain, wake and oscillator restart
      wr(CLK_CTRL1_OFS, 8'h01);
      chk({7'h0, clk_ctrl.cpu_clk_en}, 8'h01);
      wait_bit(4, 1'b0, QD + 6, n);
      chk(8'(n), 8'(QD));
      chk({3'h0, clk_ctrl}, 8'h01);
      repeat (5) @(posedge core_clk);
      #1;
      chk({3'h0, clk_ctrl}, 8'h01);
      rd(STATUS_OFS, v);
      chk(v, 8'h11);
      // wake source is a plain level, no timer pulse reaches the pin
      wake_pin <= 1'b1;
      wait_bit(1, 1'b1, 8, n);
      wake_pin <= 1'b0;
      chk({3'h0, clk_ctrl}, 8'h03);
      // oscillator restart is still running two cycles later
      rd(STATUS_OFS, v);
      chk(v, 8'h18);
      // nothing is asked of the cpu until its clock is back
      wait_bit(4, 1'b1, OS + 6, n);
      chk({3'h0, clk_ctrl}, 8'h1E);
      rd(CLK_CTRL1_OFS, v);
      chk(v, 8'h00);
      // nmi held low blocks stop entry
      nmi_n_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(STATUS_OFS, v);
      chk(v, 8'h00);
      wr(CLK_CTRL1_OFS, 8'h01);
      rd(CLK_CTRL1_OFS, v);
      chk(v, 8'h00);
      repeat (QD + 4) @(posedge core_clk);
      #1;
      chk({3'h0, clk_ctrl}, 8'h1E);
      nmi_n_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      // nmi low wakes from stop and pins the stop bit at zero
      wr(CLK_CTRL1_OFS, 8'h01);
      wait_bit(4, 1'b0, QD + 6, n);
      chk({3'h0, clk_ctrl}, 8'h01);
      nmi_n_pin <= 1'b0;
      wait_bit(1, 1'b1, 8, n);
      chk({3'h0, clk_ctrl}, 8'h03);
      rd(CLK_CTRL1_OFS, v);
      chk(v, 8'h00);
      nmi_n_pin <= 1'b1;
      wait_bit(4, 1'b1, OS + 6, n);
      chk({3'h0, clk_ctrl}, 8'h1E);
      repeat (3) @(posedge core_clk);
      // reference settle before conversions
      wr(CONV_CTRL1_OFS, 8'h20);
      chk({7'h0, vref_connect}, 8'h01);
      pulse(3'b100);
      watch_conv(seen);
      chk({7'h0, seen}, 8'h00);
      repeat (REF_SETTLE_CYC + 4) @(posedge core_clk);
      pulse(3'b100);
      watch_conv(seen);
      chk({7'h0, seen}, 8'h01);
      rd(STATUS_OFS, v);
      chk(v, 8'h14);
      wr(CONV_CTRL1_OFS, 8'h00);
      chk({7'h0, vref_connect}, 8'h00);
      // disconnecting restarts the settle time
      rd(STATUS_OFS, v);
      chk(v, 8'h10);
      report_and_stop();
   end
endmodule
`default_nettype wire
